// file: rtl/scan_cache_pkg.sv
// Shared constants and types for the scan cache parameter access block
package scan_cache_pkg;
   localparam int VALUE_W = 9;
   localparam int CNT_SEL_W = 4;
   localparam int PAR_SEL_W = 3;
   localparam int NUM_COUNTERS = 16;
   localparam int NUM_PARAMS = 8;
   // Cycles spent fetching once busy is up
   localparam int FETCH_CYCLES = 2;
   localparam int FETCH_CNT_W = 2;
   localparam logic [VALUE_W-1:0] VALUE_RST = 9'h000;
   localparam logic [CNT_SEL_W-1:0] FIRST_OUTPUT_COUNTER = 4'h4;
   // Parameter codes and their widths
   localparam logic [PAR_SEL_W-1:0] PAR_HIGH_COUNT = 3'h0;
   localparam logic [PAR_SEL_W-1:0] PAR_LOW_COUNT = 3'h1;
   localparam logic [PAR_SEL_W-1:0] PAR_BYPASS = 3'h4;
   localparam logic [PAR_SEL_W-1:0] PAR_ODD_DIV = 3'h5;

   typedef logic [VALUE_W-1:0] value_t;

   // Mask of the low-order bits that a parameter occupies
   function automatic value_t param_mask(input logic [PAR_SEL_W-1:0] par);
      value_t m;
      m = 9'h000;
      unique case (par)
         PAR_HIGH_COUNT, PAR_LOW_COUNT: m = 9'h0ff;
         PAR_BYPASS, PAR_ODD_DIV: m = 9'h001;
         default: m = 9'h1ff;
      endcase
      return m;
   endfunction : param_mask
endpackage : scan_cache_pkg

// file: rtl/scan_cache_if.sv
// Interface joining user logic to the scan cache parameter access core
`timescale 1ns/1ps
interface scan_cache_if;
   import scan_cache_pkg::*;
   logic [VALUE_W-1:0] wr_value;
   logic [CNT_SEL_W-1:0] cnt_sel;
   logic [PAR_SEL_W-1:0] par_sel;
   logic write_param;
   logic read_param;
   logic [VALUE_W-1:0] rd_value;
   logic busy;

   modport core (input wr_value, cnt_sel, par_sel, write_param, read_param, output rd_value, busy);
   modport user (output wr_value, cnt_sel, par_sel, write_param, read_param, input rd_value, busy);
endinterface : scan_cache_if

// file: rtl/scan_cache_core.sv
// Scan cache core: stores counter parameters and serves reads with busy
// Notes on behaviour
// - Nine-bit value input feeds cache writes
// - Write keeps only the parameter's low bits
// - Unconnected value input reads as zero
// - Four-bit counter select picks the counter
// - Three-bit parameter select picks field, width
// - Read request sampled each edge, fetches value
// - User pulses read request one cycle only
// - Busy rises next edge, holds during read
// - User ignores read value while busy
// - Value valid once busy drops
// - Powers up reset; user resets first anyway
// - Reset input must always be connected
// - Clock input must be a running clock
`timescale 1ns/1ps
module scan_cache_core
   import scan_cache_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   scan_cache_if.core bus
);
   // =============================================
   // Local sizes
   // One slot per parameter code of every counter
   localparam int CACHE_IDX_W = CNT_SEL_W + PAR_SEL_W;
   localparam int CACHE_DEPTH = NUM_COUNTERS * NUM_PARAMS;

   // =============================================
   // Types
   // The cache is either open to strobes or serving one read
   typedef enum logic [1:0] {ST_IDLE, ST_BUSY} core_state_e;

   // Cache slot index, counter select above parameter select
   typedef logic [CACHE_IDX_W-1:0] cache_idx_t;

   // Whole core state, registered as one image
   typedef struct packed {
      core_state_e state;
      logic [FETCH_CNT_W-1:0] cnt;
      logic [CNT_SEL_W-1:0] cnt_sel;
      logic [PAR_SEL_W-1:0] par_sel;
      logic [VALUE_W-1:0] rd_value;
      logic [CACHE_DEPTH-1:0][VALUE_W-1:0] cache;
   } core_s;

   // Power-up and reset image: idle, empty cache, zero read value
   localparam core_s CORE_RST = '{
      state: ST_IDLE,
      cnt: '0,
      cnt_sel: '0,
      par_sel: '0,
      rd_value: VALUE_RST,
      cache: '0
   };

   // =============================================
   // Helpers
   // Flat cache slot of one parameter of one counter
   function automatic cache_idx_t cache_index
   (
      input logic [CNT_SEL_W-1:0] cnt,
      input logic [PAR_SEL_W-1:0] par
   );
      return {cnt, par};
   endfunction : cache_index

   // Word as the cache keeps it: a floating input counts as zero and
   // only the bits that the parameter is wide survive
   function automatic value_t stored_value
   (
      input value_t raw,
      input logic [PAR_SEL_W-1:0] par
   );
      value_t v;

      v = raw;
      if ($isunknown(raw))
      begin
         v = VALUE_RST;
      end
      return v & param_mask(par);
   endfunction : stored_value

   // Word as the read port shows it, narrow fields zero-extended
   function automatic value_t fetched_value
   (
      input value_t word,
      input logic [PAR_SEL_W-1:0] par
   );
      return word & param_mask(par);
   endfunction : fetched_value

   // =============================================
   // Signals
   // Register image and its next value
   core_s st_r;
   core_s st_nxt;

   // Decoded strobes
   logic idle;
   logic take_write;
   logic take_read;

   // Fetch counter
   logic fetch_last;
   logic [FETCH_CNT_W-1:0] fetch_load;

   // Cache slots and words
   cache_idx_t wr_idx;
   cache_idx_t rd_idx;
   value_t wr_word;
   value_t rd_word;

   // =============================================
   // Request decode
   // Strobes only count while idle; a busy core drops them without a sign,
   // so the user end must wait for busy to fall before the next request
   assign idle = (st_r.state == ST_IDLE);
   assign take_write = bus.write_param && idle;
   assign take_read = bus.read_param && idle;

   // Counter holds the fetch cycles still to come after the current one
   assign fetch_load = FETCH_CNT_W'(FETCH_CYCLES - 1);
   assign fetch_last = (st_r.cnt == '0);

   // Write side works on the live selects, read side on the captured ones
   assign wr_idx = cache_index(bus.cnt_sel, bus.par_sel);
   assign rd_idx = cache_index(st_r.cnt_sel, st_r.par_sel);
   assign wr_word = stored_value(bus.wr_value, bus.par_sel);
   assign rd_word = fetched_value(st_r.cache[rd_idx], st_r.par_sel);

   // Read timeline in core clock edges:
   //   edge 0: strobe seen while idle, selects captured, busy rises after it
   //   edges 1 to FETCH_CYCLES-1: fetch counter runs down, busy stays high
   //   edge FETCH_CYCLES: word lands in the read value, busy falls after it
   //   afterwards the word stands until the next read completes
   //   strobes seen while busy are lost; the requester keeps the spacing

   // =============================================
   // Next state
   always_comb
   begin
      st_nxt = st_r;

      // A write in the cycle a read is taken still lands, and the fetch sees it
      if (take_write)
      begin
         st_nxt.cache[wr_idx] = wr_word;
      end

      // Read handshake
      unique case (st_r.state)
         ST_IDLE:
         begin
            // Selects are frozen here so a later change cannot steer this read
            if (take_read)
            begin
               st_nxt.state = ST_BUSY;
               st_nxt.cnt = fetch_load;
               st_nxt.cnt_sel = bus.cnt_sel;
               st_nxt.par_sel = bus.par_sel;
            end
         end

         ST_BUSY:
         begin
            // Further requests fall on the floor here
            if (fetch_last)
            begin
               st_nxt.rd_value = rd_word;
               st_nxt.state = ST_IDLE;
            end
            else
            begin
               st_nxt.cnt = st_r.cnt - 1'b1;
            end
         end

         default:
         begin
            st_nxt.state = ST_IDLE;
         end
      endcase
   end

   // =============================================
   // State register
   // Reset clears the whole cache image, so a fresh read returns zero
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= CORE_RST;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // =============================================
   // Outputs
   // Read value comes straight from flip-flops; busy is decoded from the registered state
   assign bus.rd_value = st_r.rd_value;
   assign bus.busy = (st_r.state == ST_BUSY);

endmodule : scan_cache_core

// file: rtl/scan_cache_user.sv
// User end: turns read and write commands into the core handshake
`timescale 1ns/1ps
module scan_cache_user
   import scan_cache_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic rd_req_in,
   input wire logic wr_req_in,
   input wire logic [CNT_SEL_W-1:0] cnt_sel_in,
   input wire logic [PAR_SEL_W-1:0] par_sel_in,
   input wire logic [VALUE_W-1:0] wr_value_in,
   output logic ready_out,
   output logic rd_done_out,
   output logic [VALUE_W-1:0] rd_value_out,
   scan_cache_if.user bus
);
   typedef enum logic [1:0] {U_IDLE, U_ISSUE, U_WAIT} user_state_e;

   typedef struct packed {
      user_state_e state;
      logic read_param;
      logic write_param;
      logic [CNT_SEL_W-1:0] cnt_sel;
      logic [PAR_SEL_W-1:0] par_sel;
      logic [VALUE_W-1:0] wr_value;
      logic done;
      logic [VALUE_W-1:0] rd_value;
   } user_s;

   user_s st_r;
   user_s st_nxt;

   // =============================================
   // Next state
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.read_param = 1'b0;
      st_nxt.write_param = 1'b0;
      st_nxt.done = 1'b0;
      unique case (st_r.state)
         U_IDLE:
         begin
            // Held off for the cycle a write strobe is still out
            if ((rd_req_in || wr_req_in) && ready_out)
            begin
               st_nxt.cnt_sel = cnt_sel_in;
               st_nxt.par_sel = par_sel_in;
               st_nxt.wr_value = wr_value_in;
               st_nxt.read_param = rd_req_in;
               st_nxt.write_param = !rd_req_in;
               st_nxt.state = rd_req_in ? U_ISSUE : U_IDLE;
            end
         end
         // Busy shows one edge after the pulse, so skip a cycle
         U_ISSUE: st_nxt.state = U_WAIT;
         U_WAIT:
         begin
            if (!bus.busy)
            begin
               st_nxt.rd_value = bus.rd_value;
               st_nxt.done = 1'b1;
               st_nxt.state = U_IDLE;
            end
         end
         default: st_nxt.state = U_IDLE;
      endcase
   end

   // =============================================
   // State register
   always_ff @(posedge sys_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign bus.read_param = st_r.read_param;
   assign bus.write_param = st_r.write_param;
   assign bus.cnt_sel = st_r.cnt_sel;
   assign bus.par_sel = st_r.par_sel;
   assign bus.wr_value = st_r.wr_value;
   assign ready_out = (st_r.state == U_IDLE) && !st_r.write_param && !st_r.read_param;
   assign rd_done_out = st_r.done;
   assign rd_value_out = st_r.rd_value;
endmodule : scan_cache_user

// file: testbench/scan_cache_checker.sv
// Assertions on the core handshake
`timescale 1ns/1ps
module scan_cache_checker
   import scan_cache_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic read_param,
   input wire logic write_param,
   input wire logic busy,
   input wire logic [VALUE_W-1:0] rd_value
);
   // ====
   // Checks
   default clocking dc @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   a_busy_rise: assert property (read_param && !busy |=> busy) else $error("busy late");
   a_busy_cause: assert property ($rose(busy) |-> $past(read_param)) else $error("busy uncaused");
   a_busy_two: assert property ($rose(busy) |=> busy ##1 !busy) else $error("busy length");
   a_busy_bound: assert property (busy |-> ##[1:2] !busy) else $error("busy stuck");
   a_value_hold: assert property (!$stable(rd_value) |-> $fell(busy)) else $error("value moved");
   a_reset_idle: assert property ($rose(rst_n_in) |-> !busy && rd_value == '0) else $error("bad reset");
   a_one_read: assert property (read_param |=> !read_param) else $error("long read");
   a_write_idle: assert property (write_param |-> !busy) else $error("write in read");
endmodule : scan_cache_checker

// file: testbench/testbench.sv
// Self-checking bench for both ends
`timescale 1ns/1ps
module testbench;
   import scan_cache_pkg::*;
   logic sys_clk_in = 0;
   logic rst_n_in = 0;
   logic rd_req_in = 0;
   logic wr_req_in = 0;
   logic [CNT_SEL_W-1:0] cnt_sel_in = '0;
   logic [PAR_SEL_W-1:0] par_sel_in = '0;
   logic [VALUE_W-1:0] wr_value_in = '0;
   logic ready_out, rd_done_out;
   logic [VALUE_W-1:0] rd_value_out;
   int fails = 0;
   int check_count = 0;
   int cyc = 0;
   int mdl [128];
   scan_cache_if bus ();
   scan_cache_core scan_cache_core_inst (.sys_clk_in, .rst_n_in, .bus);
   scan_cache_user scan_cache_user_inst (.sys_clk_in, .rst_n_in, .rd_req_in, .wr_req_in, .cnt_sel_in,
      .par_sel_in, .wr_value_in, .ready_out, .rd_done_out, .rd_value_out, .bus);
   scan_cache_checker scan_cache_checker_inst (.sys_clk_in, .rst_n_in, .read_param(bus.read_param),
      .write_param(bus.write_param), .busy(bus.busy), .rd_value(bus.rd_value));
   // ====
   // Clock, hang guard, helpers
   always #10 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         fails++;
         print_verdict();
      end
   end
   task print_verdict;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task chk(input logic [VALUE_W-1:0] got, exp);
      check_count++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // Field width per parameter code
   function automatic int msk(int p);
      return p < 2 ? 'hff : (p == 4 || p == 5) ? 1 : 'h1ff;
   endfunction : msk
   task automatic op(input bit rd, input int c, p, input logic [VALUE_W-1:0] v);
      int n;
      n = 0;
      while (ready_out !== 1'b1 && n < 50)
      begin
         @(posedge sys_clk_in);
         #1 n++;
      end
      rd_req_in = rd;
      wr_req_in = !rd;
      cnt_sel_in = c[3:0];
      par_sel_in = p[2:0];
      wr_value_in = v;
      @(posedge sys_clk_in);
      #1 rd_req_in = 0;
      wr_req_in = 0;
      wr_value_in = '0;
      chk(9'(ready_out), 9'h000);
      if (!rd)
         mdl[c*8+p] = $isunknown(v) ? 0 : v & msk(p);
      n = 0;
      while (rd && rd_done_out !== 1'b1 && n < 50)
      begin
         @(posedge sys_clk_in);
         #1 n++;
      end
      if (rd)
      begin
         chk(n[8:0], 9'(FETCH_CYCLES + 2));
         chk(rd_value_out, mdl[c*8+p][8:0]);
      end
   endtask : op
   // ====
   // Main sequence
   initial
   begin
      void'($urandom(32'hb4ee));
      repeat (6) @(posedge sys_clk_in);
      #1 rst_n_in = 1;
      for (int p = 0; p < 8; p++)
      begin
         op(0, FIRST_OUTPUT_COUNTER, p, 9'h1ff);
         op(1, FIRST_OUTPUT_COUNTER, p, 0);
      end
      op(0, 2, 3, 'x);
      op(1, 2, 3, 0);
      // A write offered while a read runs must be dropped
      op(0, 1, 6, 9'h0a5);
      @(posedge sys_clk_in);
      #1 rd_req_in = 1;
      cnt_sel_in = 4'h1;
      par_sel_in = 3'h6;
      @(posedge sys_clk_in);
      #1 rd_req_in = 0;
      wr_req_in = 1;
      wr_value_in = 9'h15a;
      @(posedge sys_clk_in);
      #1 wr_req_in = 0;
      wr_value_in = '0;
      repeat (3) @(posedge sys_clk_in);
      #1 chk(9'(rd_done_out), 9'h001);
      chk(rd_value_out, mdl[14][8:0]);
      op(1, 1, 6, 0);
      for (int i = 0; i < 60; i++)
         op(bit'($urandom % 2), $urandom % 4 + 3, $urandom % 8, 9'($urandom));
      // Reset in mid-run empties the cache
      @(posedge sys_clk_in);
      #1 rst_n_in = 0;
      foreach (mdl[i])
         mdl[i] = 0;
      repeat (2) @(posedge sys_clk_in);
      #1 rst_n_in = 1;
      op(1, FIRST_OUTPUT_COUNTER, 0, 0);
      print_verdict();
   end
endmodule : testbench
